//--- wcd_pkg.sv
// Purpose: constants for the watchdog-clear and decrement execution block
// Assumes: 14-bit instruction words, 8-bit data, 128-entry file space
// Notes:   register map is reached over APB, one aligned 32-bit word each
// Behaviour
// - watchdog-clear opcode forces watchdog counter zero
// - watchdog-clear also zeroes the watchdog prescaler
// - watchdog-clear sets timeout and powerdown flags only
// - decrement decoded from 000011, dest bit, address
// - dest zero: result to accumulator, file unchanged
// - dest one: result written back to file
// - decrement updates zero flag, nothing else
`default_nettype none

package wcd_pkg;

  // instruction format
  localparam int          INSTR_W        = 14;
  localparam int          DATA_W         = 8;
  localparam int          FADDR_W        = 7;
  localparam int          FILE_DEPTH     = 128;
  localparam logic [13:0] OP_CLEAR_WDOG  = 14'h0064;
  localparam logic [5:0]  OP_DEC_FILE    = 6'h03;
  localparam int          OP_HI_POS      = 8;
  localparam int          DEST_POS       = 7;

  // watchdog sizes
  localparam int          WDOG_W         = 8;
  localparam int          PRESC_W        = 8;
  localparam logic [7:0]  PRESC_LAST     = 8'hff;
  localparam logic [7:0]  WDOG_LAST      = 8'hff;

  // apb byte offsets
  localparam logic [7:0]  OFF_CTRL       = 8'h00;
  localparam logic [7:0]  OFF_STATUS     = 8'h04;
  localparam logic [7:0]  OFF_ACCUM      = 8'h08;
  localparam logic [7:0]  OFF_WDOG       = 8'h0c;
  localparam logic [7:0]  OFF_FADDR      = 8'h10;
  localparam logic [7:0]  OFF_FDATA      = 8'h14;

  // field positions
  localparam int          CTRL_EXEC_POS  = 0;
  localparam int          ST_ZERO_POS    = 0;
  localparam int          ST_PD_N_POS    = 1;
  localparam int          ST_TO_N_POS    = 2;
  localparam int          WDOG_PRESC_POS = 8;

  // reset values
  localparam logic        RST_EXEC_EN    = 1'b1;
  localparam logic        RST_FLAG_N     = 1'b1;
  localparam logic        RST_ZERO       = 1'b0;
  localparam logic [7:0]  RST_BYTE       = 8'h00;

endpackage

`default_nettype wire

//--- wcd_exec.sv
// Purpose: executes the watchdog-clear and decrement-file instructions
// Assumes: one decoded word per cycle on instr_valid; apb master keeps the protocol
// Notes:   instruction writes win over a same-cycle apb file write
`default_nettype none

module wcd_exec (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // instruction stream from decode
  input  wire logic        instr_valid,
  input  wire logic [13:0] instr_word,
  // watchdog time base
  input  wire logic        wdog_tick,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // core state
  output logic [7:0]       accum,
  output logic             zero_flag,
  output logic             timeout_flag_n,
  output logic             powerdown_flag_n,
  output logic [7:0]       watchdog_counter,
  output logic [7:0]       wdog_prescaler,
  output logic             exec_done
);

  function automatic logic is_clear_wdog(input logic [13:0] w);
    is_clear_wdog = (w == wcd_pkg::OP_CLEAR_WDOG);
  endfunction

  function automatic logic is_dec_file(input logic [13:0] w);
    is_dec_file = (w[13:wcd_pkg::OP_HI_POS] == wcd_pkg::OP_DEC_FILE);
  endfunction

  function automatic logic [7:0] dec8(input logic [7:0] v);
    dec8 = v - 8'h01;
  endfunction

  // file space
  logic [7:0]  file_mem [wcd_pkg::FILE_DEPTH];

  // control registers
  logic        exec_en_ff;
  logic        nxt_exec_en;
  logic [6:0]  faddr_ff;
  logic [6:0]  nxt_faddr;

  // core state
  logic [7:0]  accum_ff;
  logic [7:0]  nxt_accum;
  logic        zero_ff;
  logic        nxt_zero;
  logic        to_n_ff;
  logic        nxt_to_n;
  logic        pd_n_ff;
  logic        nxt_pd_n;
  logic [7:0]  wdog_ff;
  logic [7:0]  nxt_wdog;
  logic [7:0]  presc_ff;
  logic [7:0]  nxt_presc;
  logic        done_ff;
  logic        nxt_done;

  // apb answer
  logic        pready_ff;
  logic        nxt_pready;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        pslverr_ff;
  logic        nxt_pslverr;

  // file write port
  logic        file_we;
  logic [6:0]  file_waddr;
  logic [7:0]  file_wdata;

  // decode
  logic        run;
  logic        do_clear;
  logic        do_dec;
  logic        dest_file;
  logic [6:0]  op_addr;
  logic [7:0]  dec_res;
  logic        apb_setup;
  logic        apb_commit;
  logic        addr_hit;

  always_comb begin
    run        = instr_valid && exec_en_ff;
    do_clear   = run && is_clear_wdog(instr_word);
    do_dec     = run && is_dec_file(instr_word);
    dest_file  = instr_word[wcd_pkg::DEST_POS];
    op_addr    = instr_word[6:0];
    dec_res    = dec8(file_mem[op_addr]);
    apb_setup  = psel && !penable;
    apb_commit = psel && penable && pready_ff;
  end

  // core state next values
  always_comb begin
    nxt_accum = accum_ff;
    nxt_zero  = zero_ff;
    nxt_to_n  = to_n_ff;
    nxt_pd_n  = pd_n_ff;
    nxt_wdog  = wdog_ff;
    nxt_presc = presc_ff;
    nxt_done  = do_clear || do_dec;
    // free-running time base; overflow of the counter marks a timeout
    if (wdog_tick) begin
      if (presc_ff == wcd_pkg::PRESC_LAST) begin
        nxt_presc = wcd_pkg::RST_BYTE;
        if (wdog_ff == wcd_pkg::WDOG_LAST) begin
          nxt_wdog = wcd_pkg::RST_BYTE;
          nxt_to_n = 1'b0;
        end else begin
          nxt_wdog = wdog_ff + 8'h01;
        end
      end else begin
        nxt_presc = presc_ff + 8'h01;
      end
    end
    // the instruction outranks a same-cycle tick
    if (do_clear) begin
      nxt_wdog  = wcd_pkg::RST_BYTE;
      nxt_presc = wcd_pkg::RST_BYTE;
      nxt_to_n  = 1'b1;
      nxt_pd_n  = 1'b1;
    end
    if (do_dec) begin
      nxt_zero = (dec_res == 8'h00);
      if (!dest_file) begin
        nxt_accum = dec_res;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      accum_ff <= wcd_pkg::RST_BYTE;
      zero_ff  <= wcd_pkg::RST_ZERO;
      to_n_ff  <= wcd_pkg::RST_FLAG_N;
      pd_n_ff  <= wcd_pkg::RST_FLAG_N;
      wdog_ff  <= wcd_pkg::RST_BYTE;
      presc_ff <= wcd_pkg::RST_BYTE;
      done_ff  <= 1'b0;
    end else begin
      accum_ff <= nxt_accum;
      zero_ff  <= nxt_zero;
      to_n_ff  <= nxt_to_n;
      pd_n_ff  <= nxt_pd_n;
      wdog_ff  <= nxt_wdog;
      presc_ff <= nxt_presc;
      done_ff  <= nxt_done;
    end
  end

  // file write port: decrement write-back has priority over apb
  always_comb begin
    file_we    = 1'b0;
    file_waddr = faddr_ff;
    file_wdata = pwdata[7:0];
    if (do_dec && dest_file) begin
      file_we    = 1'b1;
      file_waddr = op_addr;
      file_wdata = dec_res;
    end else if (apb_commit && pwrite && paddr == wcd_pkg::OFF_FDATA) begin
      file_we    = 1'b1;
    end
  end

  // memory holds no reset; software initialises it
  always_ff @(posedge clock) begin
    if (file_we) begin
      file_mem[file_waddr] <= file_wdata;
    end
  end

  // control register next values
  always_comb begin
    nxt_exec_en = exec_en_ff;
    nxt_faddr   = faddr_ff;
    if (apb_commit && pwrite) begin
      case (paddr)
        wcd_pkg::OFF_CTRL:  nxt_exec_en = pwdata[wcd_pkg::CTRL_EXEC_POS];
        wcd_pkg::OFF_FADDR: nxt_faddr = pwdata[6:0];
        default:            nxt_faddr = faddr_ff;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      exec_en_ff <= wcd_pkg::RST_EXEC_EN;
      faddr_ff   <= 7'h00;
    end else begin
      exec_en_ff <= nxt_exec_en;
      faddr_ff   <= nxt_faddr;
    end
  end

  // apb answer: one wait-free access after the setup cycle
  always_comb begin
    nxt_pready  = 1'b0;
    nxt_prdata  = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    addr_hit    = 1'b1;
    if (apb_setup) begin
      nxt_pready = 1'b1;
      case (paddr)
        wcd_pkg::OFF_CTRL:   nxt_prdata[wcd_pkg::CTRL_EXEC_POS] = exec_en_ff;
        wcd_pkg::OFF_STATUS: begin
          nxt_prdata[wcd_pkg::ST_ZERO_POS] = zero_ff;
          nxt_prdata[wcd_pkg::ST_PD_N_POS] = pd_n_ff;
          nxt_prdata[wcd_pkg::ST_TO_N_POS] = to_n_ff;
        end
        wcd_pkg::OFF_ACCUM:  nxt_prdata[7:0] = accum_ff;
        wcd_pkg::OFF_WDOG: begin
          nxt_prdata[7:0]  = wdog_ff;
          nxt_prdata[15:8] = presc_ff;
        end
        wcd_pkg::OFF_FADDR:  nxt_prdata[6:0] = faddr_ff;
        wcd_pkg::OFF_FDATA:  nxt_prdata[7:0] = file_mem[faddr_ff];
        default:             addr_hit = 1'b0;
      endcase
      nxt_pslverr = !addr_hit;
      if (!addr_hit) begin
        nxt_prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= nxt_pready;
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  assign pready           = pready_ff;
  assign prdata           = prdata_ff;
  assign pslverr          = pslverr_ff;
  assign accum            = accum_ff;
  assign zero_flag        = zero_ff;
  assign timeout_flag_n   = to_n_ff;
  assign powerdown_flag_n = pd_n_ff;
  assign watchdog_counter = wdog_ff;
  assign wdog_prescaler   = presc_ff;
  assign exec_done        = done_ff;

endmodule

`default_nettype wire

//--- wcd_monitor.sv
// Purpose: port checks for the execution block
// Assumes: exec enable low only while counters and flags are already clear
// Notes:   tick cycles skipped where the timeout may move
`default_nettype none
module wcd_monitor (
  // clock and reset
  input wire logic        clock,
  input wire logic        srst,
  // stimulus
  input wire logic        instr_valid,
  input wire logic [13:0] instr_word,
  input wire logic        wdog_tick,
  // state
  input wire logic [7:0]  accum,
  input wire logic        zero_flag,
  input wire logic        timeout_flag_n,
  input wire logic        powerdown_flag_n,
  input wire logic [7:0]  watchdog_counter,
  input wire logic [7:0]  wdog_prescaler,
  input wire logic        exec_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_clr; instr_valid && instr_word == 14'h0064; endsequence
  sequence s_dec; instr_valid && instr_word[13:8] == 6'h03; endsequence
  property p_wdog; s_clr |=> watchdog_counter == 8'h00; endproperty
  a_wdog: assert property (p_wdog) else $error("counter kept");
  property p_presc; s_clr |=> wdog_prescaler == 8'h00; endproperty
  a_presc: assert property (p_presc) else $error("prescaler kept");
  property p_flags;
    s_clr |=> timeout_flag_n && powerdown_flag_n && $stable(zero_flag) && $stable(accum);
  endproperty
  a_flags: assert property (p_flags) else $error("clear flags wrong");
  property p_odd;
    instr_valid && instr_word != 14'h0064 && instr_word[13:8] != 6'h03 |=> !exec_done;
  endproperty
  a_odd: assert property (p_odd) else $error("stray opcode ran");
  property p_acc; s_dec ##0 !instr_word[7] |=> exec_done; endproperty
  a_acc: assert property (p_acc) else $error("decrement lost");
  property p_file; s_dec ##0 instr_word[7] |=> exec_done && $stable(accum); endproperty
  a_file: assert property (p_file) else $error("accum moved");
  property p_keep;
    s_dec ##0 !wdog_tick |=> $stable(timeout_flag_n) && $stable(powerdown_flag_n);
  endproperty
  a_keep: assert property (p_keep) else $error("flags moved");
  property p_zero; s_dec ##0 !instr_word[7] |=> zero_flag == (accum == 8'h00); endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_pulse; s_clr ##1 !instr_valid |=> !exec_done; endproperty
  a_pulse: assert property (p_pulse) else $error("done too long");
endmodule
bind wcd_exec wcd_monitor u_mon (.clock, .srst, .instr_valid, .instr_word, .wdog_tick,
  .accum, .zero_flag, .timeout_flag_n, .powerdown_flag_n, .watchdog_counter,
  .wdog_prescaler, .exec_done);
`default_nettype wire

//--- wcd_exec_test.sv
// Purpose: self-checking bench for the execution block
// Assumes: exec enable dropped only once, with watchdog state already clear
// Notes:   full watchdog wrap costs 65536 ticks, inside the limit
`default_nettype none
module wcd_exec_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, srst, instr_valid, wdog_tick, err;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [13:0] instr_word;
  logic [7:0]  paddr, accum, watchdog_counter, wdog_prescaler;
  logic [31:0] pwdata, prdata, rd;
  logic        zero_flag, timeout_flag_n, powerdown_flag_n, exec_done;
  logic [31:0] seed = 32'hd6154f3a;
  int          fail_count, samples_checked, cyc, acc, z, a, v, r, d;
  int          fm [128];
  wcd_exec uut (.clock, .srst, .instr_valid, .instr_word, .wdog_tick, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .accum, .zero_flag,
    .timeout_flag_n, .powerdown_flag_n, .watchdog_counter, .wdog_prescaler, .exec_done);
  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end
  function automatic logic [31:0] lfsr();
    seed = {seed[30:0], 1'h0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] dt);
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= dt;
    @(posedge clock);
    penable <= 1'h1;
    do @(posedge clock); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic ex(input logic [13:0] w);
    @(posedge clock);
    instr_valid <= 1'h1;
    instr_word <= w;
    @(posedge clock);
    instr_valid <= 1'h0;
    @(negedge clock);
  endtask
  task automatic summarize();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    {srst, instr_valid, wdog_tick, psel, penable, pwrite} = 6'h20;
    instr_word = 14'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (10) @(posedge clock);
    srst <= 1'h0;
    apb(1'h0, 8'h04, 32'h0);
    chk(rd, 32'h6);
    apb(1'h0, 8'h18, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    for (int i = 0; i < 12; i++) begin
      a = lfsr() & 32'h7f;
      v = (i < 3) ? i : lfsr() & 32'hff;
      d = (i < 3) ? i % 2 : lfsr() & 32'h1;
      apb(1'h1, 8'h10, a);
      apb(1'h1, 8'h14, v);
      fm[a] = v;
      r = (v + 255) % 256;
      ex({6'h03, 1'(d), 7'(a)});
      if (d) fm[a] = r;
      else acc = r;
      z = (r == 0);
      chk(accum, acc);
      chk({exec_done, zero_flag}, {1'h1, 1'(z)});
      chk({timeout_flag_n, powerdown_flag_n}, 32'h3);
      apb(1'h0, 8'h14, 32'h0);
      chk(rd, fm[a]);
    end
    ex(14'h0065);
    chk({exec_done, accum}, acc);
    ex(14'h0b00);
    chk({exec_done, accum}, acc);
    apb(1'h1, 8'h08, 32'h5a);
    apb(1'h0, 8'h08, 32'h0);
    chk(rd, acc);
    // 65836 ticks: one full wrap plus 300
    @(posedge clock);
    wdog_tick <= 1'h1;
    repeat (65836) @(posedge clock);
    wdog_tick <= 1'h0;
    @(negedge clock);
    chk({timeout_flag_n, watchdog_counter, wdog_prescaler}, 32'h0012c);
    ex(14'h0064);
    chk(watchdog_counter, 32'h0);
    chk(wdog_prescaler, 32'h0);
    chk({timeout_flag_n, powerdown_flag_n, zero_flag, accum}, {2'h3, 1'(z), 8'(acc)});
    // execution disabled: a clear must be ignored, no done pulse
    apb(1'h1, 8'h00, 32'h0);
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    ex(14'h0064);
    chk(exec_done, 32'h0);
    apb(1'h1, 8'h00, 32'h1);
    apb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h1);
    summarize();
  end
endmodule
`default_nettype wire
